// ==== src/port_mode_irq_control.sv ====
// Purpose: Port mode control and status word with three sticky interrupts
// Assumes: Avalon-MM slave, all inputs synchronous to i_clk
// Notes:   Answers every access with waitrequest low in the third cycle
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/100ps

// Overview of operation
// - Decode disabled: every non-maintenance packet reaches logical layer
// - Decode enabled: only base ID packets forwarded
// - Bit 25 picks interrupt or self-reset
// - Self-reset bit low: interrupt instead of reset
// - Self-reset bit high: request reset, restore defaults
// - Check enabled: mismatched maintenance packets go MAC
// - Check disabled: maintenance requests handled whatever ID
// - Bits 23 to 6 read zero
// - Multicast enable drives interrupt on event
// - Multicast status sticky, write one clears
// - Reset enable drives interrupt after sequence
// - Reset status sticky, write one clears
// - Port-write enable drives interrupt on arrival
// - Port-write status sets after payload capture
// - Payload captured into four read-only words
module port_mode_irq_control
  import port_mode_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Link events
  input wire logic [PORTS-1:0] i_mcast_sym,
  input wire logic i_rst_sym,
  input wire logic i_other_sym,
  input wire pw_s i_pw,
  // Received packets
  input wire pkt_s i_pkt,
  input wire logic [DEST_W-1:0] i_base_id,
  // Packet routing strobes
  output logic o_pkt_to_logical,
  output logic o_pkt_dropped,
  output logic o_maint_to_mac,
  output logic o_maint_local,
  // Reset controller request
  output logic o_self_reset_req,
  // Interrupts
  output logic o_mcast_irq_out,
  output logic o_rst_irq_out,
  output logic o_portwrite_irq_out,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q; // Release shift chain
  logic rst_n; // Synchronised reset used everywhere

  // Assert at once, release after two edges
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic dest_id_decode_disable_q; // Bit 26
  logic self_reset_q; // Bit 25
  logic maint_id_check_disable_q; // Bit 24
  logic mcast_irq_enable_q; // Bit 5
  logic mcast_irq_status_q; // Bit 4
  logic rst_irq_enable_q; // Bit 3
  logic rst_irq_status_q; // Bit 2
  logic portwrite_irq_enable_q; // Bit 1
  logic portwrite_irq_status_q; // Bit 0
  logic [31:0] mode_word; // Read view of the mode register
  logic seq_done; // Four reset symbols in a row
  logic pw_captured_q; // Payload now stored
  logic soft_rst; // Self-reset wipes our own registers

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  bus_state_e state_q; // Access phase
  logic req; // Master holds a request
  logic wr_take; // Write takes effect this edge
  logic hit_mode; // Address selects the mode word
  logic hit_capt; // Address selects a capture word
  logic [31:0] capt_rdata; // Registered capture read data
  logic [31:0] wmask; // Byte enables widened to bits
  logic [31:0] wbits; // Masked write data

  assign req = i_avs_read | i_avs_write;
  assign hit_mode = (i_avs_address == ADDR_MODE);
  assign hit_capt = (i_avs_address >= ADDR_CAPT0) && (i_avs_address <= ADDR_CAPT3)
    && (i_avs_address[1:0] == 2'b00);
  assign wr_take = (state_q == BUS_ACK) && i_avs_write;
  assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign wbits = i_avs_writedata & wmask;

  // Idle, fetch, then one cycle with waitrequest low
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (req) begin
            state_q <= BUS_FETCH;
          end
        end
        BUS_FETCH: begin
          // Capture read data is ready now
          state_q <= BUS_ACK;
          o_avs_waitrequest <= 1'b0;
        end
        BUS_ACK: begin
          state_q <= BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
        default: begin
          state_q <= BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read data loaded as waitrequest falls; unmapped reads give zero
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (state_q == BUS_FETCH) begin
      if (!i_avs_read) begin
        o_avs_readdata <= 32'h0000_0000;
      end else if (hit_mode) begin
        o_avs_readdata <= mode_word;
      end else if (hit_capt) begin
        o_avs_readdata <= capt_rdata;
      end else begin
        o_avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Reserved bits tie to zero in the read view
  always_comb begin
    mode_word = MODE_RESET;
    mode_word[BIT_DEST_DIS] = dest_id_decode_disable_q;
    mode_word[BIT_SELF_RST] = self_reset_q;
    mode_word[BIT_MAINT_DIS] = maint_id_check_disable_q;
    mode_word[BIT_MCAST_EN] = mcast_irq_enable_q;
    mode_word[BIT_MCAST_ST] = mcast_irq_status_q;
    mode_word[BIT_RST_EN] = rst_irq_enable_q;
    mode_word[BIT_RST_ST] = rst_irq_status_q;
    mode_word[BIT_PORTWRITE_IRQ_ENABLE] = portwrite_irq_enable_q;
    mode_word[BIT_PW_ST] = portwrite_irq_status_q;
  end

  // ----------------------------------------------------------------
  // Control and enable bits
  // ----------------------------------------------------------------
  // Self-reset returns these to their defaults too
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      {dest_id_decode_disable_q, self_reset_q, maint_id_check_disable_q} <= CTRL_RESET;
      {mcast_irq_enable_q, rst_irq_enable_q, portwrite_irq_enable_q} <= EN_RESET;
    end else if (soft_rst) begin
      {dest_id_decode_disable_q, self_reset_q, maint_id_check_disable_q} <= CTRL_RESET;
      {mcast_irq_enable_q, rst_irq_enable_q, portwrite_irq_enable_q} <= EN_RESET;
    end else if (wr_take && hit_mode) begin
      if (i_avs_byteenable[3]) begin
        dest_id_decode_disable_q <= i_avs_writedata[BIT_DEST_DIS];
        self_reset_q <= i_avs_writedata[BIT_SELF_RST];
        maint_id_check_disable_q <= i_avs_writedata[BIT_MAINT_DIS];
      end
      if (i_avs_byteenable[0]) begin
        mcast_irq_enable_q <= i_avs_writedata[BIT_MCAST_EN];
        rst_irq_enable_q <= i_avs_writedata[BIT_RST_EN];
        portwrite_irq_enable_q <= i_avs_writedata[BIT_PORTWRITE_IRQ_ENABLE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset symbol sequence
  // ----------------------------------------------------------------
  reset_seq_detect #(
    .COUNT(RST_SYM_COUNT)
  ) u_seq (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_rst_sym(i_rst_sym),
    .i_other_sym(i_other_sym),
    .o_seq_done(seq_done)
  );

  // Bit 25 decides between reset request and interrupt
  assign soft_rst = seq_done && self_reset_q;

  // Pulse toward the reset controller
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_self_reset_req <= 1'b0;
    end else begin
      o_self_reset_req <= soft_rst;
    end
  end

  // ----------------------------------------------------------------
  // Port-write capture
  // ----------------------------------------------------------------
  pw_capture_mem #(
    .WORDS(PW_WORDS)
  ) u_capt (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_wr(i_pw.valid),
    .i_wdata(i_pw.payload),
    .i_raddr(i_avs_address[3:2]),
    .o_rdata(capt_rdata)
  );

  // Status follows one edge after the payload is stored
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_captured_q <= 1'b0;
    end else begin
      pw_captured_q <= i_pw.valid;
    end
  end

  // ----------------------------------------------------------------
  // Sticky status bits
  // ----------------------------------------------------------------
  logic w1c_mcast; // Software clears multicast
  logic w1c_rst; // Software clears reset status
  logic w1c_pw; // Software clears port-write

  assign w1c_mcast = wr_take && hit_mode && wbits[BIT_MCAST_ST];
  assign w1c_rst = wr_take && hit_mode && wbits[BIT_RST_ST];
  assign w1c_pw = wr_take && hit_mode && wbits[BIT_PW_ST];

  // Set beats a write-one clear; only a self-reset drops an event
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      {mcast_irq_status_q, rst_irq_status_q, portwrite_irq_status_q} <= ST_RESET;
    end else if (soft_rst) begin
      {mcast_irq_status_q, rst_irq_status_q, portwrite_irq_status_q} <= ST_RESET;
    end else begin
      // Events set whatever the enables say
      mcast_irq_status_q <= (|i_mcast_sym) | (mcast_irq_status_q & ~w1c_mcast);
      rst_irq_status_q <= seq_done | (rst_irq_status_q & ~w1c_rst);
      portwrite_irq_status_q <= pw_captured_q | (portwrite_irq_status_q & ~w1c_pw);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  logic irq_d; // Any enabled status bit

  // Enables gate only the combined line
  assign irq_d = (mcast_irq_enable_q & mcast_irq_status_q)
    | (rst_irq_enable_q & rst_irq_status_q)
    | (portwrite_irq_enable_q & portwrite_irq_status_q);

  // Registered copies keep outputs glitch free; one cycle behind status
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_mcast_irq_out <= 1'b0;
      o_rst_irq_out <= 1'b0;
      o_portwrite_irq_out <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_mcast_irq_out <= mcast_irq_status_q;
      o_rst_irq_out <= rst_irq_status_q;
      o_portwrite_irq_out <= portwrite_irq_status_q;
      o_irq <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Packet filter
  // ----------------------------------------------------------------
  logic id_match; // Destination equals base ID

  assign id_match = (i_pkt.dest_id == i_base_id);

  // One strobe per packet, a cycle after it is seen
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pkt_to_logical <= 1'b0;
      o_pkt_dropped <= 1'b0;
      o_maint_to_mac <= 1'b0;
      o_maint_local <= 1'b0;
    end else begin
      o_pkt_to_logical <= 1'b0;
      o_pkt_dropped <= 1'b0;
      o_maint_to_mac <= 1'b0;
      o_maint_local <= 1'b0;
      if (i_pkt.valid && i_pkt.maint) begin
        if (maint_id_check_disable_q || id_match) begin
          o_maint_local <= 1'b1;
        end else begin
          o_maint_to_mac <= 1'b1;
        end
      end else if (i_pkt.valid) begin
        if (dest_id_decode_disable_q) begin
          o_pkt_to_logical <= 1'b1;
        end else if (id_match) begin
          o_pkt_to_logical <= 1'b1;
        end else begin
          o_pkt_dropped <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_decode_off_fwd: assert property (i_pkt.valid && !i_pkt.maint && dest_id_decode_disable_q
    |=> o_pkt_to_logical) else $error("packet not forwarded with decode off");
  a_mismatch_drop: assert property (i_pkt.valid && !i_pkt.maint && !dest_id_decode_disable_q
    && !id_match |=> o_pkt_dropped && !o_pkt_to_logical)
    else $error("mismatched packet not dropped");
  a_self_rst_req: assert property (seq_done && self_reset_q |=> o_self_reset_req
    && !self_reset_q && !rst_irq_status_q) else $error("self reset not taken");
  a_seq_irq_set: assert property (seq_done && !self_reset_q |=> rst_irq_status_q ##1
    o_rst_irq_out) else $error("reset status not raised");
  a_maint_mac: assert property (i_pkt.valid && i_pkt.maint && !maint_id_check_disable_q
    && !id_match |=> o_maint_to_mac) else $error("maintenance packet not sent to mac");
  a_maint_local: assert property (i_pkt.valid && i_pkt.maint && maint_id_check_disable_q
    |=> o_maint_local) else $error("maintenance packet not handled");
  a_reserved_zero: assert property (state_q == BUS_FETCH && i_avs_read && hit_mode
    |=> o_avs_readdata[23:6] == 18'h0) else $error("reserved bits read nonzero");
  a_mcast_irq: assert property (|i_mcast_sym && mcast_irq_enable_q && !soft_rst
    |-> ##2 o_irq) else $error("multicast interrupt missing");
  a_mcast_sticky: assert property (mcast_irq_status_q && !w1c_mcast && !soft_rst
    |=> mcast_irq_status_q) else $error("multicast status lost");
  a_rst_irq: assert property (rst_irq_status_q && rst_irq_enable_q |=> o_irq)
    else $error("reset interrupt missing");
  a_pw_enable_irq: assert property (portwrite_irq_status_q && portwrite_irq_enable_q
    |=> o_irq) else $error("port-write interrupt missing");
  a_pw_capture: assert property (i_pw.valid && !soft_rst ##1 !soft_rst |=> portwrite_irq_status_q
    ##1 o_portwrite_irq_out) else $error("port-write status late");
  // Checks the registered line: a write may set an enable at this same edge
  a_irq_masked: assert property (!mcast_irq_enable_q && !rst_irq_enable_q
    && !portwrite_irq_enable_q |=> !o_irq) else $error("masked interrupt raised");

  c_pw_read: cover property (portwrite_irq_status_q && state_q == BUS_ACK && hit_capt);
  c_self_reset: cover property (o_self_reset_req);
  c_clear_race: cover property (w1c_mcast && |i_mcast_sym);
  c_maint_mac: cover property (o_maint_to_mac);

endmodule

// ==== pkg/port_mode_pkg.sv ====
// Purpose: Shared constants and carriers for the port mode and irq block
// Assumes: Avalon-MM byte addresses, 32-bit data words
// Notes:   All reset values of the mode register are zero
package port_mode_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CAPT0 = 8'h10;
  localparam logic [7:0] ADDR_CAPT3 = 8'h1c;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int BIT_DEST_DIS = 26;
  localparam int BIT_SELF_RST = 25;
  localparam int BIT_MAINT_DIS = 24;
  localparam int BIT_MCAST_EN = 5;
  localparam int BIT_MCAST_ST = 4;
  localparam int BIT_RST_EN = 3;
  localparam int BIT_RST_ST = 2;
  localparam int BIT_PORTWRITE_IRQ_ENABLE = 1;
  localparam int BIT_PW_ST = 0;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [2:0] EN_RESET = 3'h0;
  localparam logic [2:0] ST_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------
  localparam int RST_SYM_COUNT = 4;
  localparam int NUM_PORTS = 4;
  localparam int DEST_W = 16;
  localparam int PW_WORDS = 4;
  localparam int PW_BITS = 128;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Received packet header seen by the filter
  typedef struct packed {
    logic valid;
    logic maint;
    logic [DEST_W-1:0] dest_id;
  } pkt_s;

  // Inbound port-write payload
  typedef struct packed {
    logic valid;
    logic [PW_BITS-1:0] payload;
  } pw_s;

  // Bus handshake states, one-hot
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_FETCH = 3'b010,
    BUS_ACK = 3'b100
  } bus_state_e;

endpackage

// ==== src/pw_capture_mem.sv ====
// Purpose: Holds the four captured port-write payload words
// Assumes: Whole payload written in one cycle
// Notes:   Read data come out of a register, one cycle after the address
`timescale 1ns/100ps
module pw_capture_mem
  import port_mode_pkg::*;
#(
  parameter int WORDS = PW_WORDS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Write side
  input wire logic i_wr,
  input wire logic [WORDS*32-1:0] i_wdata,
  // Read side
  input wire logic [$clog2(WORDS)-1:0] i_raddr,
  output logic [31:0] o_rdata
);

  // Storage, word 0 holds the lowest payload bits
  logic [31:0] mem_q [WORDS];

  // ----------------------------------------------------------------
  // Storage per word
  // ----------------------------------------------------------------
  for (genvar g = 0; g < WORDS; g++) begin : g_word
    // Word g takes bits 32*g upward
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        mem_q[g] <= 32'h0000_0000;
      end else if (i_wr) begin
        mem_q[g] <= i_wdata[g*32 +: 32];
      end
    end
  end

  // Registered read port
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= mem_q[i_raddr];
    end
  end

endmodule

// ==== src/reset_seq_detect.sv ====
// Purpose: Detects a run of consecutive link-request reset symbols
// Assumes: One symbol strobe per cycle at most
// Notes:   A symbol on i_other_sym breaks the run; multicast symbols never reach this block
`timescale 1ns/100ps
module reset_seq_detect
  import port_mode_pkg::*;
#(
  parameter int COUNT = RST_SYM_COUNT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Symbol strobes
  input wire logic i_rst_sym,
  input wire logic i_other_sym,
  // One-cycle pulse when the run completes
  output logic o_seq_done
);

  localparam int CNT_W = $clog2(COUNT + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);

  // Symbols seen so far in the current run
  logic [CNT_W-1:0] cnt_q;

  // Run counter, restarts after a completed run
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      o_seq_done <= 1'b0;
    end else begin
      o_seq_done <= 1'b0;
      if (i_rst_sym) begin
        if (cnt_q == LAST) begin
          cnt_q <= '0;
          o_seq_done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + CNT_W'(1);
        end
      end else if (i_other_sym) begin
        cnt_q <= '0;
      end
    end
  end

endmodule

// ==== test/link_partner_model.sv ====
// Purpose: Far-side link partner sending symbols, packets and port-writes
// Assumes: The bench calls its tasks; strobes last one cycle
// Notes:   Released payload lines show the inverse value, never a stale copy
`timescale 1ns/100ps
module link_partner_model
  import port_mode_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Strobes toward the block
  output logic [NUM_PORTS-1:0] o_mcast_sym,
  output logic o_rst_sym,
  output logic o_other_sym,
  output pw_s o_pw,
  output pkt_s o_pkt
);
  // ----------------------------------------
  // Idle lines
  // ----------------------------------------
  initial begin
    o_mcast_sym = '0;
    o_rst_sym = 1'b0;
    o_other_sym = 1'b0;
    o_pw = '0;
    o_pkt = '0;
  end
  // One symbol: 0 reset, 1 other, 2+p multicast on port p
  task automatic sym(input int kind);
    @(posedge i_clk);
    if (kind == 0) o_rst_sym <= 1'b1;
    else if (kind == 1) o_other_sym <= 1'b1;
    else o_mcast_sym[kind-2] <= 1'b1;
    @(posedge i_clk);
    o_rst_sym <= 1'b0;
    o_other_sym <= 1'b0;
    o_mcast_sym <= '0;
  endtask
  // One inbound port-write, payload flipped once released
  task automatic pw(input logic [PW_BITS-1:0] data);
    @(posedge i_clk);
    o_pw <= {1'b1, data};
    @(posedge i_clk);
    o_pw <= {1'b0, ~data};
  endtask
  // One received packet header
  task automatic pkt(input logic maint, input logic [DEST_W-1:0] id);
    @(posedge i_clk);
    o_pkt <= {1'b1, maint, id};
    @(posedge i_clk);
    o_pkt <= {1'b0, ~maint, ~id};
  endtask
endmodule

// ==== test/port_mode_irq_control_tb_top.sv ====
// Purpose: Self-checking bench for the port mode and irq block
// Assumes: Avalon-MM master held until waitrequest is sampled low
// Notes:   Settling waits follow the fixed event latencies of the block
`timescale 1ns/100ps
module port_mode_irq_control_tb_top
  import port_mode_pkg::*;
;
  logic i_clk, i_nrst;
  logic [ADDR_W-1:0] adr;
  logic rd_en, wr_en, wreq;
  logic [31:0] wdat, rdat, rd;
  logic [NUM_PORTS-1:0] mcast;
  logic rsym, osym;
  pw_s pw;
  pkt_s pkt;
  logic [DEST_W-1:0] base_id;
  logic to_log, drop, to_mac, loc, srst, m_out, r_out, p_out, irq;
  int error_cnt, cmp_count;
  int pulses = 0; // Only the pulse counter below writes it afterwards
  logic [3:0] be; // Byte lanes of each access
  logic [127:0] pay;
  // ----------------------------------------
  // Clock, partner, design
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  link_partner_model partner (.i_clk(i_clk), .o_mcast_sym(mcast), .o_rst_sym(rsym),
    .o_other_sym(osym), .o_pw(pw), .o_pkt(pkt));
  port_mode_irq_control dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(adr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_mcast_sym(mcast), .i_rst_sym(rsym), .i_other_sym(osym), .i_pw(pw), .i_pkt(pkt),
    .i_base_id(base_id), .o_pkt_to_logical(to_log), .o_pkt_dropped(drop),
    .o_maint_to_mac(to_mac), .o_maint_local(loc), .o_self_reset_req(srst),
    .o_mcast_irq_out(m_out), .o_rst_irq_out(r_out), .o_portwrite_irq_out(p_out), .o_irq(irq));
  // Count reset requests; a pulse is too short to poll
  always @(posedge i_clk) begin
    if (srst === 1'b1) pulses++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("Counts: %0d errors, %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access, held until waitrequest is low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    adr <= a;
    wdat <= d;
    rd_en <= !we;
    wr_en <= we;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (wreq === 1'b0) break;
    end
    rd = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      $display("ERROR %0t: bus timeout", $time);
      give_verdict();
    end
  endtask
  // Let status, per-bit outputs and irq settle
  task automatic settle;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_nrst = 1'b0;
    {adr, rd_en, wr_en, wdat} = '0;
    be = 4'hf;
    base_id = 16'h1234;
    error_cnt = 0;
    cmp_count = 0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (5) @(posedge i_clk);
    // Reset value, reserved bits, unmapped and read-only places
    bus(0, ADDR_MODE, 0);
    chk(rd, MODE_RESET);
    bus(1, ADDR_MODE, 32'hffff_ffff);
    bus(0, ADDR_MODE, 0);
    chk(rd, 32'h0700_002a);
    // Low lane only: enables clear, control bits in the top lane stay
    be <= 4'h1;
    bus(1, ADDR_MODE, 0);
    be <= 4'hf;
    bus(0, ADDR_MODE, 0);
    chk(rd, 32'h0700_0000);
    bus(0, 8'h40, 0);
    chk(rd, 32'h0);
    bus(1, ADDR_CAPT0, 32'hffff_ffff);
    bus(0, ADDR_CAPT0, 0);
    chk(rd, 32'h0);
    // Every filter mode against maint flag and ID match
    for (int i = 0; i < 16; i++) begin
      bus(1, ADDR_MODE, (i[0] << BIT_DEST_DIS) | (i[1] << BIT_MAINT_DIS));
      partner.pkt(i[2], i[3] ? base_id : ~base_id);
      #1;
      chk({to_log, drop, to_mac, loc}, {!i[2] && (i[0] || i[3]), !i[2] && !(i[0] || i[3]),
        i[2] && !(i[1] || i[3]), i[2] && (i[1] || i[3])});
    end
    // Multicast: status records while disabled, enable gates irq
    bus(1, ADDR_MODE, 0);
    partner.sym(4);
    settle();
    chk({m_out, irq}, 2'b10);
    bus(1, ADDR_MODE, 1 << BIT_MCAST_EN);
    settle();
    chk(irq, 1'b1);
    bus(1, ADDR_MODE, (1 << BIT_MCAST_EN) | (1 << BIT_MCAST_ST));
    settle();
    chk({m_out, irq}, 2'b00);
    // Reset run broken by another symbol, then completed
    bus(1, ADDR_MODE, 1 << BIT_RST_EN);
    for (int k = 0; k < 5; k++) partner.sym(k == 3);
    settle();
    bus(0, ADDR_MODE, 0);
    chk(rd, 1 << BIT_RST_EN);
    for (int k = 0; k < 3; k++) partner.sym(0);
    settle();
    chk({r_out, irq}, 2'b11);
    bus(1, ADDR_MODE, (1 << BIT_RST_EN) | (1 << BIT_RST_ST));
    bus(0, ADDR_MODE, 0);
    chk(rd, 1 << BIT_RST_EN);
    // Port-write capture and status
    pay = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    bus(1, ADDR_MODE, 1 << BIT_PORTWRITE_IRQ_ENABLE);
    partner.pw(pay);
    settle();
    chk({p_out, irq}, 2'b11);
    for (int w = 0; w < 4; w++) begin
      bus(0, ADDR_CAPT0 + 8'(4 * w), 0);
      chk(rd, pay[32*w +: 32]);
    end
    bus(1, ADDR_MODE, (1 << BIT_PORTWRITE_IRQ_ENABLE) | (1 << BIT_PW_ST));
    bus(0, ADDR_MODE, 0);
    chk(rd, 1 << BIT_PORTWRITE_IRQ_ENABLE);
    // Self-reset: request instead of interrupt, defaults restored
    bus(1, ADDR_MODE, (1 << BIT_SELF_RST) | (1 << BIT_RST_EN) | (1 << BIT_MCAST_EN));
    for (int k = 0; k < 4; k++) partner.sym(0);
    settle();
    chk({31'(pulses), r_out}, {31'd1, 1'b0});
    bus(0, ADDR_MODE, 0);
    chk(rd, MODE_RESET);
    give_verdict();
  end
endmodule
